// ### hbsp_pkg.sv
package hbsp_pkg;
    localparam int OPC_W = 4;
    localparam int DATA_W = 4;
    localparam logic [3:0] OPC_RST = 4'h0;
    localparam logic [3:0] DATA_RST = 4'h0;
    // Start pulse length in clock cycles
    localparam int START_CYC = 4;
    localparam logic [2:0] START_CNT_LAST = 3'h3;
    localparam int OPC_DATA_SEL = 0;
    localparam int OPC_STAT_SEL = 2;
    localparam int OPC_START = 3;
    localparam real CLK_MHZ = 125.0;
endpackage : hbsp_pkg

// ### hbsp_shift.sv
`timescale 1ns/10ps
`default_nettype none
module hbsp_shift #(
    parameter int W = 4
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic load,
    input wire logic [W-1:0] load_data,
    input wire logic shift,
    input wire logic serial_in,
    output logic [W-1:0] q
);
    logic [W-1:0] next_q;

    always_comb begin
        next_q = q;
        if (load) begin
            next_q = load_data;
        end else if (shift) begin
            next_q = {q[W-2:0], serial_in};
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end
endmodule : hbsp_shift
`default_nettype wire

// ### hbsp_bridge.sv
// Operation
// - Low four bus bits during address phase become the operation code.
// - Code loads while selected with ALE high, holds while selected.
// - Selected read with code bit0 set, bit2 clear returns data register.
// - Selected read with bits 0,2 clear returns status: y/A, B, x/either, run.
// - Data register loads bus on selected write, else holds when strobes idle.
// - Any strobe low shifts data register; bit0 takes peripheral serial output.
// - Data or status appear within one read cycle, no wait states; here AD_OUT comes from a flop, one cycle after the strobe.
// - Block and peripheral share one system clock.
// - Bus drivers enabled only while selected and read strobe low.
// - Controller pulls start low four cycles; peripheral then holds it low.
//
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/10ps
`default_nettype none
module hbsp_bridge (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic CS_N,
    input wire logic ALE,
    input wire logic RD_N,
    input wire logic WR_N,
    input wire logic [hbsp_pkg::OPC_W-1:0] AD_IN,
    output logic [hbsp_pkg::OPC_W-1:0] AD_OUT,
    output logic AD_OE,
    input wire logic Y_STROBE_N,
    input wire logic X_STROBE_N,
    input wire logic LOAD_STROBE_A_N,
    input wire logic LOAD_STROBE_B_N,
    input wire logic LOAD_PULSE_A_N,
    input wire logic LOAD_PULSE_B_N,
    input wire logic Y_STATUS,
    input wire logic X_STATUS,
    input wire logic PERIPH_DOUT,
    input wire logic START_IN,
    output logic START_OUT,
    output logic START_OE,
    output logic [hbsp_pkg::OPC_W-1:0] OPCODE
);
    import hbsp_pkg::*;

    typedef enum logic [2:0] {
        HBSP_IDLE = 3'b001,
        HBSP_PULSE = 3'b010,
        HBSP_RUN = 3'b100
    } hbsp_state_t;

    logic [OPC_W-1:0] opcode;
    logic [OPC_W-1:0] next_opcode;
    logic [DATA_W-1:0] shift_q;
    logic [DATA_W-1:0] rd_mux;
    logic [DATA_W-1:0] ad_out;
    logic [DATA_W-1:0] next_ad_out;
    logic [DATA_W-1:0] status;
    logic rd_active;
    logic any_strobe;
    logic wr_sel;
    logic start_req;
    hbsp_state_t state;
    hbsp_state_t next_state;
    logic [2:0] cnt;
    logic [2:0] next_cnt;
    logic start_seen;
    logic start_sync;
    logic next_start_seen;
    logic next_start_sync;
    logic run_flag;

    assign wr_sel = !CS_N && !WR_N;
    assign any_strobe = !Y_STROBE_N
                        || !X_STROBE_N
                        || !LOAD_STROBE_A_N
                        || !LOAD_STROBE_B_N;

    always_comb begin
        next_opcode = opcode;
        if (!CS_N && ALE) begin
            next_opcode = AD_IN;
        end
    end

    // Code bits clear on reset so the first read selects status
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            opcode <= OPC_RST;
        end else begin
            opcode <= next_opcode;
        end
    end

    // Data register
    // Write wins over shift when both fall in one cycle
    hbsp_shift #(
        .W(DATA_W)
    ) u_shift (
        .clk(CLK),
        .arst_n(ARST_N),
        .load(wr_sel),
        .load_data(AD_IN),
        .shift(any_strobe),
        .serial_in(PERIPH_DOUT),
        .q(shift_q)
    );

    // Start request: a write with the start code bit set
    // A start request while busy is ignored, so the pulse is never stretched
    assign start_req = wr_sel && opcode[OPC_START] && (state == HBSP_IDLE);

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        case (state)
            HBSP_IDLE: begin
                next_cnt = 3'h0;
                if (start_req) begin
                    next_state = HBSP_PULSE;
                end
            end
            HBSP_PULSE: begin
                next_cnt = cnt + 3'h1;
                if (cnt == START_CNT_LAST) begin
                    next_state = HBSP_RUN;
                end
            end
            // Peripheral holds start low until done
            // Run flag stays up until the released wire is seen high again
            HBSP_RUN: begin
                if (start_seen) begin
                    next_state = HBSP_IDLE;
                end
            end
            default: begin
                next_state = HBSP_IDLE;
                next_cnt = 3'h0;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state <= HBSP_IDLE;
            cnt <= 3'h0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
        end
    end

    // Start line released high by pull-up; register it as an idle-high level
    // Two flops: the shared wire rises slowly through its pull-up
    always_comb begin
        next_start_sync = START_IN;
        next_start_seen = start_sync;
    end

    // Reset to the idle level so no false release follows reset
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            start_sync <= 1'b1;
            start_seen <= 1'b1;
        end else begin
            start_sync <= next_start_sync;
            start_seen <= next_start_seen;
        end
    end

    assign run_flag = (state != HBSP_IDLE);
    // Drive start low only during the pulse
    assign START_OUT = 1'b0;
    assign START_OE = (state == HBSP_PULSE);

    assign rd_active = !CS_N && !RD_N;

    assign status[0] = Y_STATUS || !LOAD_PULSE_A_N;
    assign status[1] = !LOAD_PULSE_B_N;
    // Either load pulse counts, so software sees every transfer slot
    assign status[2] = X_STATUS || !LOAD_PULSE_A_N || !LOAD_PULSE_B_N;
    assign status[3] = run_flag;

    always_comb begin
        rd_mux = '0;
        case ({opcode[OPC_STAT_SEL], opcode[OPC_DATA_SEL]})
            2'b00: begin
                rd_mux = status;
            end
            2'b01: begin
                rd_mux = shift_q;
            end
            // Other codes read as zero so a stray read never returns stale data
            default: begin
                rd_mux = '0;
            end
        endcase
        next_ad_out = ad_out;
        // Capture only during a selected read; otherwise the last word stands
        if (rd_active) begin
            next_ad_out = rd_mux;
        end
    end

    // Read data ready next cycle, no wait states
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ad_out <= '0;
        end else begin
            ad_out <= next_ad_out;
        end
    end

    // Read data come from a flop, one cycle after the strobe
    assign AD_OUT = ad_out;
    // Drivers follow the selected read; reset forces them off
    assign AD_OE = rd_active && ARST_N;
    assign OPCODE = opcode;
endmodule : hbsp_bridge
`default_nettype wire

// ### hbsp_bridge_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module hbsp_chk (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic CS_N,
    input wire logic ALE,
    input wire logic RD_N,
    input wire logic WR_N,
    input wire logic [3:0] AD_IN,
    input wire logic [3:0] AD_OUT,
    input wire logic AD_OE,
    input wire logic START_OE,
    input wire logic [3:0] OPCODE
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    sequence s_wr; !CS_N && !WR_N; endsequence
    sequence s_rd; !CS_N && !RD_N; endsequence
    a_opc_load: assert property (!CS_N && ALE |=> OPCODE == $past(AD_IN))
        else $error("opcode lost");
    a_opc_hold: assert property (!CS_N && !ALE |=> $stable(OPCODE))
        else $error("opcode moved");
    a_bus_idle: assert property (AD_OE |-> s_rd)
        else $error("bus driven");
    a_bus_drive: assert property (s_rd |-> AD_OE)
        else $error("bus not driven");
    a_data_read: assert property (s_wr ##2 ALE ##1 s_rd ##0 (OPCODE[0] && !OPCODE[2])
        |=> AD_OUT == $past(AD_IN, 4)) else $error("data wrong");
    a_read_zero: assert property (s_rd ##0 OPCODE[2] |=> AD_OUT == 4'h0)
        else $error("refused read");
    a_start_len: assert property (s_wr ##0 (OPCODE[3] && !START_OE)
        |=> START_OE [*4] ##1 !START_OE) else $error("start length");
    a_start_cause: assert property ($rose(START_OE) |-> !$past(WR_N) && $past(OPCODE[3]))
        else $error("start unasked");
    // A pulse that ends must have been high four cycles earlier, so it lasts at least four
    a_start_end: assert property ($fell(START_OE) |-> $past(START_OE, 4))
        else $error("start short");
endmodule : hbsp_chk
bind hbsp_bridge hbsp_chk u_hbsp_chk (.*);
`default_nettype wire

// ### hbsp_periph_model.sv
`timescale 1ns/10ps
`default_nettype none
module hbsp_periph_model (
    input wire logic clk,
    input wire logic [3:0] stb_n,
    input wire logic start_oe,
    output logic start_in,
    output logic dout
);
    logic [3:0] word = 4'hB;
    int busy = 0;
    always @(posedge clk) begin
        if (!(&stb_n)) word <= {word[2:0], word[3]};
        busy <= start_oe ? 20 : (busy > 0 ? busy - 1 : 0);
    end
    // Idle line shows the inverse so a stale bit never passes
    assign dout = &stb_n ? ~word[3] : word[3];
    assign start_in = !(start_oe || busy > 0);
endmodule : hbsp_periph_model
`default_nettype wire

// ### test_hbsp_bridge.sv
`timescale 1ns/10ps
`default_nettype none
module test_hbsp_bridge;
    logic clk = 1'h0, arst_n = 1'h0, cs_n = 1'h1, ale = 1'h0, rd_n = 1'h1, wr_n = 1'h1;
    logic [3:0] ad_in = 4'h0, stb_n = 4'hF, st = 4'h0, ad_out, opcode, got;
    logic start_oe, start_in, dout, ad_oe, got_oe;
    int miscompares = 0, check_count = 0;
    initial begin
        forever #4 clk = ~clk;
    end
    hbsp_bridge u_hbsp_bridge (.CLK(clk), .ARST_N(arst_n), .CS_N(cs_n), .ALE(ale), .RD_N(rd_n),
        .WR_N(wr_n), .AD_IN(ad_in), .AD_OUT(ad_out), .AD_OE(ad_oe), .Y_STROBE_N(stb_n[0]),
        .X_STROBE_N(stb_n[1]), .LOAD_STROBE_A_N(stb_n[2]), .LOAD_STROBE_B_N(stb_n[3]),
        .LOAD_PULSE_A_N(!st[2]), .LOAD_PULSE_B_N(!st[3]), .Y_STATUS(st[0]), .X_STATUS(st[1]),
        .PERIPH_DOUT(dout), .START_IN(start_in), .START_OUT(), .START_OE(start_oe), .OPCODE(opcode));
    hbsp_periph_model u_hbsp_periph_model (.clk(clk), .stb_n(stb_n), .start_oe(start_oe),
        .start_in(start_in), .dout(dout));
    task automatic chk(input logic [3:0] v, e);
        check_count++;
        if (v !== e) begin
            miscompares++;
            $display("Error %0t mismatch", $time);
        end
    endtask : chk
    task automatic acc(input logic [3:0] op, d, input logic w);
        @(posedge clk);
        {cs_n, ale, ad_in} <= {2'h1, op};
        @(posedge clk);
        {ale, ad_in, wr_n, rd_n} <= {1'h0, d, !w, w};
        #1 got_oe = ad_oe;
        @(posedge clk);
        {cs_n, wr_n, rd_n} <= 3'h7;
        #1 got = ad_out;
    endtask : acc
    task automatic end_sim;
        $display("Checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_sim
    initial begin
        repeat (6) @(posedge clk);
        arst_n <= 1'h1;
        #1 chk(opcode, 4'h0);
        acc(4'h1, 4'hA, 1'h1);
        chk({3'h0, got_oe}, 4'h0);
        acc(4'h1, 4'h0, 1'h0);
        chk(got, 4'hA);
        chk({3'h0, got_oe}, 4'h1);
        acc(4'h5, 4'h0, 1'h0);
        chk(got, 4'h0);
        for (int i = 0; i < 4; i++) begin
            acc(4'h1, 4'h0, 1'h1);
            stb_n <= ~(4'h1 << i);
            repeat (4) @(posedge clk);
            stb_n <= 4'hF;
            acc(4'h1, 4'h0, 1'h0);
            chk(got, 4'hB);
        end
        for (int i = 0; i < 16; i++) begin
            st <= 4'(i);
            acc(4'h0, 4'h0, 1'h0);
            chk(got, {1'h0, st[1] | st[2] | st[3], st[3], st[0] | st[2]});
        end
        st <= 4'h0;
        acc(4'h8, 4'h0, 1'h1);
        repeat (8) @(posedge clk);
        acc(4'h0, 4'h0, 1'h0);
        chk(got, 4'h8);
        for (int n = 0; n < 40 && got[3] !== 1'h0; n++) acc(4'h0, 4'h0, 1'h0);
        chk(got, 4'h0);
        end_sim;
    end
endmodule : test_hbsp_bridge
`default_nettype wire
